// >>> dv/prf_bus_master_model.sv
// Bus master model: issues broadcast reads and collects the response bits.
// Assumes the framer's serial outputs come on the same clock.
`timescale 1ns/10ps

module prf_bus_master_model (
  input  wire logic        clk_i,
  input  wire logic        nrst_i,
  input  wire logic        go_i,
  input  wire logic        src_i,
  input  wire logic        tx_bit_i,
  input  wire logic        tx_strobe_i,
  output logic             req_o,
  output logic             req_src_o,
  output logic [33:0]      frame_o,
  output logic [5:0]       nbits_o
);
  // ----------------------------------------------------------------------------
  // Request and collection
  // ----------------------------------------------------------------------------
  // One-cycle read request; the source line toggles when it qualifies nothing.
  always_ff @(posedge clk_i) begin
    req_o     <= nrst_i && go_i;
    req_src_o <= !nrst_i ? 1'b0 : (go_i ? src_i : ~req_src_o);
  end

  // Response bits shift in MSB first and are cleared by each new request.
  always_ff @(posedge clk_i) begin
    if (!nrst_i || go_i) begin
      frame_o <= '0;
      nbits_o <= '0;
    end else if (tx_strobe_i) begin
      frame_o <= {frame_o[32:0], tx_bit_i};
      nbits_o <= nbits_o + 6'd1;
    end
  end
endmodule // prf_bus_master_model

// >>> dv/prf_framer_sva.sv
// Concurrent checks on the ports of the periodic response framer.
// Assumes one clock and a synchronous active-low reset; bound at the foot.
`timescale 1ns/10ps

module prf_framer_sva (
  input wire logic                  clk_i,
  input wire logic                  nrst_i,
  input wire prf_pkg::prf_apb_req_t apb_i,
  input wire logic                  pready_o,
  input wire logic                  pslverr_o,
  input wire logic [31:0]           prdata_o,
  input wire logic                  tx_bit_o,
  input wire logic                  tx_strobe_o,
  input wire logic                  tx_active_o,
  input wire logic                  frame_done_o,
  input wire logic                  reply_skipped_o
);
  import prf_pkg::*;

  // --------------------------------------------------------------------------
  // Frame link and register bus properties
  // --------------------------------------------------------------------------
  // All checks share one clock and are quiet while reset is held.
  default clocking @(posedge clk_i); endclocking
  default disable iff (!nrst_i);

  property p_strobe_in_frame; tx_strobe_o |-> tx_active_o; endproperty
  a_strobe_in_frame: assert property (p_strobe_in_frame) else $error("strobe outside frame");
  property p_bit_hold; tx_active_o && !tx_strobe_o |-> $stable(tx_bit_o); endproperty
  a_bit_hold: assert property (p_bit_hold) else $error("bit changed without strobe");
  property p_strobe_gap; tx_strobe_o |=> !tx_strobe_o [*8]; endproperty
  a_strobe_gap: assert property (p_strobe_gap) else $error("strobes too close");
  property p_cadence; tx_strobe_o |-> ##[100:101] (tx_strobe_o || frame_done_o); endproperty
  a_cadence: assert property (p_cadence) else $error("bit time broken");
  property p_done_end; frame_done_o |-> !tx_active_o && $past(tx_active_o); endproperty
  a_done_end: assert property (p_done_end) else $error("done without frame end");
  property p_done_pulse; frame_done_o |=> !frame_done_o; endproperty
  a_done_pulse: assert property (p_done_pulse) else $error("done longer than a cycle");
  property p_skip_silent; reply_skipped_o |-> !tx_active_o [*8]; endproperty
  a_skip_silent: assert property (p_skip_silent) else $error("frame sent while silenced");
  property p_ready; apb_i.psel && !apb_i.penable |=> pready_o; endproperty
  a_ready: assert property (p_ready) else $error("no ready after setup");
  property p_ready_pulse; pready_o |=> !pready_o; endproperty
  a_ready_pulse: assert property (p_ready_pulse) else $error("ready held");
  property p_err_ready; pslverr_o |-> pready_o; endproperty
  a_err_ready: assert property (p_err_ready) else $error("error without ready");
  property p_rdata_idle; !pready_o |-> prdata_o == 32'h0000_0000; endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside access");
endmodule // prf_framer_sva

bind prf_periodic_response_framer prf_framer_sva u_prf_framer_sva (
  .clk_i(clk_i), .nrst_i(nrst_i), .apb_i(apb_i), .pready_o(pready_o), .pslverr_o(pslverr_o),
  .prdata_o(prdata_o), .tx_bit_o(tx_bit_o), .tx_strobe_o(tx_strobe_o), .tx_active_o(tx_active_o),
  .frame_done_o(frame_done_o), .reply_skipped_o(reply_skipped_o)
);

// >>> dv/prf_periodic_response_framer_tb_top.sv
// Top-level bench of the periodic response framer.
// Assumes the framer, its checker and the bus master model are compiled first.
`timescale 1ns/10ps

module prf_periodic_response_framer_tb_top;
  import prf_pkg::*;

  // ----------------------------------------------------------------------------
  // Signals and stimulus tables
  // ----------------------------------------------------------------------------
  typedef struct packed {
    logic        src;
    logic [14:0] flt;
    logic [3:0]  code;
  } prf_row_t;

  logic         clk_i = 1'b0;
  logic         nrst_i = 1'b0;
  prf_apb_req_t apb_r = '0;
  logic         pready_o, pslverr_o, tx_bit_o, tx_strobe_o, tx_active_o, frame_done_o, reply_skipped_o;
  logic [31:0]  prdata_o, rd;
  logic         er, req, req_src;
  prf_fault_t   flt_r = '0;
  prf_sensor_t  sens = 64'h4D44_3C33_2B22_1A11;
  logic         tmr_r = 1'b0;
  logic         go_r = 1'b0;
  logic         src_r = 1'b0;
  logic [33:0]  frm;
  logic [5:0]   nb;
  logic [1:0]   keepalive_count [2] = '{2'b00, 2'b00};
  logic [9:0]   cfg [2] = '{10'h175, 10'h0BA};
  logic         pend = 1'b0;
  logic [15:0]  errv = 16'h7FFE;
  int           mismatches = 0;
  int           check_count = 0;
  prf_row_t     rows [17] = '{'{1'b0, 15'h0000, 4'h0}, '{1'b0, 15'h0001, 4'h1}, '{1'b0, 15'h2000, 4'h2},
    '{1'b0, 15'h0800, 4'h3}, '{1'b0, 15'h0100, 4'h4}, '{1'b0, 15'h0080, 4'h5}, '{1'b0, 15'h4081, 4'h5},
    '{1'b0, 15'h0040, 4'h8}, '{1'b0, 15'h0020, 4'h9}, '{1'b0, 15'h0010, 4'hA}, '{1'b0, 15'h0008, 4'hB},
    '{1'b0, 15'h0002, 4'hD}, '{1'b0, 15'h0004, 4'hC}, '{1'b0, 15'h0042, 4'hD}, '{1'b1, 15'h1000, 4'h2},
    '{1'b1, 15'h0000, 4'h0}, '{1'b1, 15'h0400, 4'h4}};

  // Free-running 50 MHz clock.
  always #10 clk_i = ~clk_i;

  prf_periodic_response_framer u_prf_periodic_response_framer (
    .clk_i(clk_i), .nrst_i(nrst_i), .apb_i(apb_r), .pready_o(pready_o), .pslverr_o(pslverr_o),
    .prdata_o(prdata_o), .req_i(req), .req_src_i(req_src), .fault_i(flt_r), .sensor_i(sens),
    .supply_timer_expired_i(tmr_r), .tx_bit_o(tx_bit_o), .tx_strobe_o(tx_strobe_o),
    .tx_active_o(tx_active_o), .frame_done_o(frame_done_o), .reply_skipped_o(reply_skipped_o));

  prf_bus_master_model u_prf_bus_master_model (
    .clk_i(clk_i), .nrst_i(nrst_i), .go_i(go_r), .src_i(src_r), .tx_bit_i(tx_bit_o),
    .tx_strobe_i(tx_strobe_o), .req_o(req), .req_src_o(req_src), .frame_o(frm), .nbits_o(nb));

  // ----------------------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------------------
  // Prints the counts and the verdict, then stops the run.
  task automatic close_out();
    $display("checks=%0d mismatches=%0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic chk(input logic [33:0] got, input logic [33:0] exp);
    check_count++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // One APB transfer; holds the request until ready is sampled high.
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    @(posedge clk_i);
    apb_r <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: wd};
    @(posedge clk_i);
    apb_r.penable <= 1'b1;
    do begin
      @(posedge clk_i);
    end while (pready_o !== 1'b1);
    rd = prdata_o;
    er = pslverr_o;
    apb_r <= '0;
  endtask

  // Asks the master model for one broadcast read.
  task automatic pulse(input logic s);
    @(posedge clk_i);
    go_r  <= 1'b1;
    src_r <= s;
    @(posedge clk_i);
    go_r <= 1'b0;
  endtask

  // Waits a bounded time for done (sel 0) or skipped (sel 1) and checks it came.
  task automatic wait_hi(input logic sel, input int lim);
    int w;
    w = 0;
    while ((sel ? reply_skipped_o : frame_done_o) !== 1'b1 && w < lim) begin
      @(posedge clk_i);
      w++;
    end
    chk(34'(sel ? reply_skipped_o : frame_done_o), 34'd1);
  endtask

  // Builds the expected frame, requests it and compares every bit.
  task automatic frame(input logic s, input logic [3:0] code, input logic csub);
    logic [33:0] m;
    logic [7:0]  c;
    logic [15:0] d;
    int          n;
    m = '0;
    d = (csub || pend) ? errv : sens[cfg[s][8:7]];
    if (cfg[s][4]) m = {m[29:0], cfg[s][3:0]};
    if (cfg[s][5]) m = {m[31:0], keepalive_count[s]};
    if (cfg[s][6]) m = {m[29:0], code};
    m = {m[17:0], d};
    n = 16 + 4 * cfg[s][4] + 2 * cfg[s][5] + 4 * cfg[s][6];
    c = {4'h0, cfg[s][3:0]};
    for (int i = n + 7; i >= 0; i--) c = {c[6:0], (i >= 8) ? m[i - 8] : 1'b0} ^ (c[7] ? CRC_POLY : 8'h00);
    pulse(s);
    wait_hi(1'b0, 5000);
    chk(frm, {m[25:0], c});
    chk(34'(nb), 34'(n + 8));
    pend = csub;
    keepalive_count[s] = keepalive_count[s] + 2'd1;
  endtask

  // ----------------------------------------------------------------------------
  // Sequences
  // ----------------------------------------------------------------------------
  // Cuts a hung run short; the full sequence needs about 66000 cycles.
  initial begin
    repeat (90000) @(posedge clk_i);
    mismatches++;
    close_out();
  end

  initial begin
    repeat (4) @(posedge clk_i);
    nrst_i <= 1'b1;
    apb(1'b0, OFS_SRC0, '0);
    chk(34'(rd), 34'(SRC0_RST));
    apb(1'b0, OFS_SRC1, '0);
    chk(34'(rd), 34'(SRC1_RST));
    apb(1'b0, OFS_ERRVAL, '0);
    chk(34'(rd), 34'(ERRVAL_RST));
    apb(1'b0, 8'h20, '0);
    chk(34'({er, rd}), 34'h1_0000_0000);
    pulse(1'b0);
    repeat (300) @(posedge clk_i);
    chk(34'(nb), 34'd0);
    apb(1'b1, OFS_SRC0, 32'h0000_0175);
    apb(1'b1, OFS_SRC1, 32'h0000_00BA);
    apb(1'b1, OFS_ERRVAL, 32'h8001_7FFE);
    apb(1'b1, OFS_CTRL, 32'h0000_0001);
    foreach (rows[i]) begin
      @(posedge clk_i);
      flt_r <= rows[i].flt;
      frame(rows[i].src, rows[i].code, rows[i].code >= 4'h8 || (rows[i].code != 4'h0 && !cfg[rows[i].src][6]));
      flt_r <= '0;
    end
    apb(1'b1, OFS_CTRL, 32'h0000_0003);
    flt_r <= 15'h0004;
    pulse(1'b0);
    wait_hi(1'b1, 20);
    chk(34'(nb), 34'd0);
    tmr_r <= 1'b1;
    frame(1'b0, 4'hC, 1'b1);
    flt_r <= '0;
    tmr_r <= 1'b0;
    apb(1'b1, OFS_SRC1, 32'h0000_02BA);
    cfg[1] = 10'h2BA;
    errv = 16'h8001;
    flt_r <= 15'h0008;
    frame(1'b1, 4'hB, 1'b1);
    close_out();
  end
endmodule // prf_periodic_response_framer_tb_top

// >>> hw/prf_crc8.sv
// Serial augmented CRC-8 engine of the periodic response framer.
// Assumes the caller feeds message bits MSB first, then eight zeros.
`timescale 1ns/10ps

module prf_crc8 (
  input  wire logic       clk_i,
  input  wire logic       nrst_i,
  input  wire logic       load_i,
  input  wire logic [7:0] seed_i,
  input  wire logic       step_i,
  input  wire logic       bit_i,
  output logic      [7:0] crc_o
);
  import prf_pkg::*;

  // Loads the seed, then shifts one bit in per step with polynomial feedback.
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      crc_o <= 8'h00;
    end else if (load_i) begin
      crc_o <= seed_i;
    end else if (step_i) begin
      crc_o <= {crc_o[6:0], bit_i} ^ (crc_o[7] ? CRC_POLY : 8'h00);
    end
  end

endmodule // prf_crc8

// >>> hw/prf_periodic_response_framer.sv
// Periodic response framer: builds status, data and CRC frames on broadcast reads.
// Assumes req_i comes from the command decoder on the same clock, and that fault
// flags and sensor words are synchronous to clk_i. Registers sit on APB.
`timescale 1ns/10ps

module prf_periodic_response_framer (
  input  wire logic                 clk_i,
  input  wire logic                 nrst_i,
  input  wire prf_pkg::prf_apb_req_t apb_i,
  output logic                      pready_o,
  output logic                      pslverr_o,
  output logic [31:0]               prdata_o,
  input  wire logic                 req_i,
  input  wire logic                 req_src_i,
  input  wire prf_pkg::prf_fault_t   fault_i,
  input  wire prf_pkg::prf_sensor_t  sensor_i,
  input  wire logic                 supply_timer_expired_i,
  output logic                      tx_bit_o,
  output logic                      tx_strobe_o,
  output logic                      tx_active_o,
  output logic                      frame_done_o,
  output logic                      reply_skipped_o
);
  import prf_pkg::*;

  // ----------------------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------------------
  logic [31:0]        ctrl_r;
  prf_src_cfg_t       src_cfg_r [2];
  logic [31:0]        errval_r;
  prf_state_t         state_r;
  logic [FRM_W-1:0]   frame_r;
  logic [FRM_W-1:0]   calc_sr_r;
  logic [FRM_W-1:0]   tx_sr_r;
  logic [5:0]         len_r;
  logic [5:0]         cnt_r;
  logic [5:0]         bits_left_r;
  logic               cur_src_r;
  logic [KAC_W-1:0]   kac_r [2];
  logic [3:0]         last_code_r;
  logic               subst_pend_r;
  logic [7:0]         div_r;
  logic               bit_tick_r;
  logic [15:0]        cond;
  logic [3:0]         code;
  prf_src_cfg_t       cfg;
  logic               any_signed;
  logic               subst_now;
  logic               no_reply;
  logic               accept;
  logic [DATA_W-1:0]  data_sel;
  logic [PAY_W-1:0]   acc;
  logic [5:0]         nbits;
  logic [FRM_W-1:0]   frame_nxt;
  logic [7:0]         crc;
  logic               apb_setup;
  logic               apb_wr;
  logic               addr_hit;

  // ----------------------------------------------------------------------------
  // APB slave
  // ----------------------------------------------------------------------------

  // A setup cycle arms pready for the access phase; the write lands at the edge that ends the access phase.
  assign apb_setup = apb_i.psel & ~apb_i.penable;
  assign apb_wr    = apb_i.psel & apb_i.penable & pready_o & apb_i.pwrite;
  assign addr_hit  = (apb_i.paddr == OFS_CTRL) || (apb_i.paddr == OFS_SRC0) || (apb_i.paddr == OFS_SRC1) ||
                     (apb_i.paddr == OFS_ERRVAL) || (apb_i.paddr == OFS_STAT);

  // Ready, error and read data are registered during the setup cycle.
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      pready_o  <= 1'b0;
      pslverr_o <= 1'b0;
      prdata_o  <= 32'h0000_0000;
    end else begin
      pready_o  <= apb_setup;
      pslverr_o <= apb_setup & ~addr_hit;
      prdata_o  <= 32'h0000_0000;
      if (apb_setup && !apb_i.pwrite) begin
        unique case (apb_i.paddr)
          OFS_CTRL:   prdata_o <= ctrl_r;
          OFS_SRC0:   prdata_o <= {{(32-SRC_CFG_W){1'b0}}, src_cfg_r[0]};
          OFS_SRC1:   prdata_o <= {{(32-SRC_CFG_W){1'b0}}, src_cfg_r[1]};
          OFS_ERRVAL: prdata_o <= errval_r;
          OFS_STAT:   prdata_o <= {22'h00_0000, last_code_r, kac_r[1], kac_r[0], subst_pend_r,
                                   (state_r != ST_IDLE)};
          default:    prdata_o <= 32'h0000_0000;
        endcase
      end
    end
  end

  // Control, source configuration and error value registers.
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      ctrl_r       <= CTRL_RST;
      src_cfg_r[0] <= prf_src_cfg_t'(SRC0_RST[SRC_CFG_W-1:0]);
      src_cfg_r[1] <= prf_src_cfg_t'(SRC1_RST[SRC_CFG_W-1:0]);
      errval_r     <= ERRVAL_RST;
    end else if (apb_wr) begin
      unique case (apb_i.paddr)
        OFS_CTRL:   ctrl_r       <= {30'h0000_0000, apb_i.pwdata[1:0]};
        OFS_SRC0:   src_cfg_r[0] <= prf_src_cfg_t'(apb_i.pwdata[SRC_CFG_W-1:0]);
        OFS_SRC1:   src_cfg_r[1] <= prf_src_cfg_t'(apb_i.pwdata[SRC_CFG_W-1:0]);
        OFS_ERRVAL: errval_r     <= apb_i.pwdata;
        default:    ;
      endcase
    end
  end

  // ----------------------------------------------------------------------------
  // Status selection
  // ----------------------------------------------------------------------------

  // Condition vector indexed by status code; reserved codes never assert.
  always_comb begin
    cond     = 16'h0000;
    cond[0]  = 1'b1;
    cond[1]  = fault_i.user_array_region_unlocked;
    cond[2]  = fault_i.selftest_unfinished | fault_i.selftest_running | fault_i.selftest_fault;
    cond[3]  = fault_i.osc_train_fault;
    cond[4]  = fault_i.pressure_over_limit | fault_i.pressure_under_limit |
               fault_i.pressure_channel_disagree;
    cond[5]  = fault_i.temp_fault;
    cond[8]  = fault_i.user_otp_fault;
    cond[9]  = fault_i.user_rw_fault;
    cond[10] = fault_i.factory_otp_fault;
    cond[11] = fault_i.test_active_flag;
    cond[12] = fault_i.supply_fault;
    cond[13] = fault_i.reset_occurred_flag;
  end

  prf_status_prio u_prio (
    .cond_i (cond),
    .code_o (code)
  );

  // Substitution decision; the source line means nothing without req_i, so per-source cases wait for it.
  always_comb begin
    cfg        = src_cfg_r[req_src_i];
    any_signed = src_cfg_r[0].sgn | src_cfg_r[1].sgn;
    no_reply   = (code == CODE_SUPPLY) & ctrl_r[CTRL_SUPOFF_BIT] & ~supply_timer_expired_i;
    subst_now  = (code >= CODE_MEMLO) |
                 ((code >= CODE_UNLOCK) & (code < CODE_MEMLO) & ~cfg.fmt[FMT_STAT_BIT] & req_i);
    accept     = req_i & ctrl_r[CTRL_EN_BIT] & (state_r == ST_IDLE);
  end

  // A substitution seen at any time is kept until a response accepted with none current has carried it.
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      subst_pend_r <= 1'b0;
    end else if (subst_now) begin
      subst_pend_r <= 1'b1;
    end else if (accept && !no_reply) begin
      subst_pend_r <= 1'b0;
    end
  end

  // ----------------------------------------------------------------------------
  // Frame assembly
  // ----------------------------------------------------------------------------

  // Packs enabled fields MSB first and left-aligns them with room for the CRC.
  always_comb begin
    if (subst_now || subst_pend_r) begin
      data_sel = any_signed ? errval_r[ERR_SGN_LSB +: DATA_W] : errval_r[ERR_UNS_LSB +: DATA_W];
    end else begin
      data_sel = sensor_i[cfg.dtype];
    end
    acc   = '0;
    nbits = 6'd0;
    if (cfg.fmt[FMT_ID_BIT]) begin
      acc   = {acc[PAY_W-ID_W-1:0], cfg.ident};
      nbits = nbits + 6'(ID_W);
    end
    if (cfg.fmt[FMT_KAC_BIT]) begin
      acc   = {acc[PAY_W-KAC_W-1:0], kac_r[req_src_i]};
      nbits = nbits + 6'(KAC_W);
    end
    if (cfg.fmt[FMT_STAT_BIT]) begin
      acc   = {acc[PAY_W-STAT_W-1:0], code};
      nbits = nbits + 6'(STAT_W);
    end
    acc       = {acc[PAY_W-DATA_W-1:0], data_sel};
    nbits     = nbits + 6'(DATA_W);
    frame_nxt = {acc << (6'(PAY_W) - nbits), {CRC_W{1'b0}}};
  end

  prf_crc8 u_crc (
    .clk_i  (clk_i),
    .nrst_i (nrst_i),
    .load_i (accept & ~no_reply),
    .seed_i ({4'h0, cfg.ident}),
    .step_i (state_r == ST_CALC),
    .bit_i  (calc_sr_r[FRM_W-1]),
    .crc_o  (crc)
  );

  // ----------------------------------------------------------------------------
  // Bit rate divider
  // ----------------------------------------------------------------------------

  // One-cycle bit tick; restarted when a frame is loaded so bit one is full width.
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      div_r      <= 8'h00;
      bit_tick_r <= 1'b0;
    end else if (state_r == ST_FILL || div_r == 8'(BIT_CYC - 1)) begin
      div_r      <= 8'h00;
      bit_tick_r <= (state_r != ST_FILL);
    end else begin
      div_r      <= div_r + 8'h01;
      bit_tick_r <= 1'b0;
    end
  end

  // ----------------------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------------------

  // Idle takes a request, calc runs the CRC, fill appends it, send shifts out.
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      state_r     <= ST_IDLE;
      frame_r     <= '0;
      calc_sr_r   <= '0;
      tx_sr_r     <= '0;
      len_r       <= 6'd0;
      cnt_r       <= 6'd0;
      bits_left_r <= 6'd0;
      cur_src_r   <= 1'b0;
      last_code_r <= CODE_NORMAL;
    end else begin
      unique case (state_r)
        ST_IDLE: begin
          if (accept && !no_reply) begin
            frame_r     <= frame_nxt;
            calc_sr_r   <= frame_nxt;
            len_r       <= nbits;
            cnt_r       <= 6'd0;
            cur_src_r   <= req_src_i;
            last_code_r <= code;
            state_r     <= ST_CALC;
          end
        end
        ST_CALC: begin
          calc_sr_r <= calc_sr_r << 1;
          cnt_r     <= cnt_r + 6'd1;
          if (cnt_r == len_r + 6'd7) begin
            state_r <= ST_FILL;
          end
        end
        ST_FILL: begin
          tx_sr_r     <= frame_r | ({crc, {PAY_W{1'b0}}} >> len_r);
          bits_left_r <= len_r + 6'(CRC_W);
          state_r     <= ST_SEND;
        end
        ST_SEND: begin
          if (bit_tick_r) begin
            tx_sr_r     <= tx_sr_r << 1;
            if (bits_left_r == 6'd0) begin
              state_r <= ST_IDLE;
            end else begin
              bits_left_r <= bits_left_r - 6'd1;
            end
          end
        end
      endcase
    end
  end

  // Serial outputs, one bit per tick, then a done pulse after the last bit time.
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      tx_bit_o     <= 1'b0;
      tx_strobe_o  <= 1'b0;
      tx_active_o  <= 1'b0;
      frame_done_o <= 1'b0;
    end else begin
      tx_strobe_o  <= 1'b0;
      frame_done_o <= 1'b0;
      if (state_r == ST_SEND && bit_tick_r) begin
        if (bits_left_r == 6'd0) begin
          tx_active_o  <= 1'b0;
          tx_bit_o     <= 1'b0;
          frame_done_o <= 1'b1;
        end else begin
          tx_active_o <= 1'b1;
          tx_bit_o    <= tx_sr_r[FRM_W-1];
          tx_strobe_o <= 1'b1;
        end
      end
    end
  end

  // Keepalive counts per source, advanced once a response has fully gone out.
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      kac_r[0] <= 2'h0;
      kac_r[1] <= 2'h0;
    end else if (state_r == ST_SEND && bit_tick_r && bits_left_r == 6'd0) begin
      kac_r[cur_src_r] <= kac_r[cur_src_r] + 2'h1;
    end
  end

  // Pulse when a request is dropped because the supply fault silences the reply.
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      reply_skipped_o <= 1'b0;
    end else begin
      reply_skipped_o <= accept & no_reply;
    end
  end

endmodule // prf_periodic_response_framer

// >>> hw/prf_pkg.sv
// Shared constants, types and register map of the periodic response framer.
// Assumes a single 50 MHz clock and a synchronous active-low reset everywhere.

package prf_pkg;

  // ----------------------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------------------
  localparam int unsigned CLK_HZ      = 50_000_000;
  localparam int unsigned BIT_TIME_NS = 2000;
  localparam int unsigned BIT_CYC     = (BIT_TIME_NS * (CLK_HZ / 1_000_000)) / 1000;

  // ----------------------------------------------------------------------------
  // Register map (byte addresses) and reset values
  // ----------------------------------------------------------------------------
  localparam logic [7:0]  OFS_CTRL   = 8'h00;
  localparam logic [7:0]  OFS_SRC0   = 8'h04;
  localparam logic [7:0]  OFS_SRC1   = 8'h08;
  localparam logic [7:0]  OFS_ERRVAL = 8'h0C;
  localparam logic [7:0]  OFS_STAT   = 8'h10;
  localparam logic [31:0] CTRL_RST   = 32'h0000_0000;
  localparam logic [31:0] SRC0_RST   = 32'h0000_0071;
  localparam logic [31:0] SRC1_RST   = 32'h0000_0072;
  localparam logic [31:0] ERRVAL_RST = 32'h8000_0000;

  // Control bits and field positions.
  localparam int unsigned CTRL_EN_BIT     = 0;
  localparam int unsigned CTRL_SUPOFF_BIT = 1;
  localparam int unsigned SRC_CFG_W       = 10;
  localparam int unsigned ERR_UNS_LSB     = 0;
  localparam int unsigned ERR_SGN_LSB     = 16;
  localparam int unsigned FMT_ID_BIT      = 0;
  localparam int unsigned FMT_KAC_BIT     = 1;
  localparam int unsigned FMT_STAT_BIT    = 2;

  // ----------------------------------------------------------------------------
  // Frame widths and CRC
  // ----------------------------------------------------------------------------
  localparam int unsigned ID_W   = 4;
  localparam int unsigned KAC_W  = 2;
  localparam int unsigned STAT_W = 4;
  localparam int unsigned DATA_W = 16;
  localparam int unsigned CRC_W  = 8;
  localparam int unsigned PAY_W  = ID_W + KAC_W + STAT_W + DATA_W;
  localparam int unsigned FRM_W  = PAY_W + CRC_W;
  localparam logic [7:0]  CRC_POLY = 8'h2F;

  // Status codes.
  localparam logic [3:0] CODE_NORMAL = 4'h0;
  localparam logic [3:0] CODE_UNLOCK = 4'h1;
  localparam logic [3:0] CODE_MEMLO  = 4'h8;
  localparam logic [3:0] CODE_SUPPLY = 4'hC;

  // Codes from least to most urgent; later entries win.
  localparam logic [3:0] PRIO_ORDER [16] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h7, 4'h6,
                                             4'h8, 4'h9, 4'hA, 4'hB, 4'hC, 4'hD, 4'hF, 4'hE};

  // ----------------------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------------------
  typedef struct packed {
    logic       sgn;
    logic [1:0] dtype;
    logic [2:0] fmt;
    logic [3:0] ident;
  } prf_src_cfg_t;

  typedef struct packed {
    logic       psel;
    logic       penable;
    logic       pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
  } prf_apb_req_t;

  typedef struct packed {
    logic selftest_unfinished;
    logic selftest_running;
    logic selftest_fault;
    logic osc_train_fault;
    logic pressure_over_limit;
    logic pressure_under_limit;
    logic pressure_channel_disagree;
    logic temp_fault;
    logic user_otp_fault;
    logic user_rw_fault;
    logic factory_otp_fault;
    logic test_active_flag;
    logic supply_fault;
    logic reset_occurred_flag;
    logic user_array_region_unlocked;
  } prf_fault_t;

  typedef logic [3:0][DATA_W-1:0] prf_sensor_t;

  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_CALC = 4'b0010,
    ST_FILL = 4'b0100,
    ST_SEND = 4'b1000
  } prf_state_t;

endpackage

// >>> hw/prf_status_prio.sv
// Status priority selector of the periodic response framer.
// Assumes a condition vector indexed by status code, from same-clock logic.
`timescale 1ns/10ps

module prf_status_prio (
  input  wire logic [15:0] cond_i,
  output logic      [3:0]  code_o
);
  import prf_pkg::*;

  // Walks codes from least to most urgent so the most urgent active one wins.
  always_comb begin
    code_o = CODE_NORMAL;
    for (int i = 0; i < 16; i++) begin
      if (cond_i[PRIO_ORDER[i]]) begin
        code_o = PRIO_ORDER[i];
      end
    end
  end

endmodule // prf_status_prio
